// *** include/hub_port_consts.svh ***
/*
 constants for the hub downstream port control block: register indexes,
 reset values, field codes and bus answers.
 assumes it is included by bare name after the package.
*/
`ifndef HUB_PORT_CONSTS_SVH
`define HUB_PORT_CONSTS_SVH

// register indexes; byte address is four times the index
`define IDX_ENABLES 8'h49
`define IDX_SPEED 8'h4a
`define IDX_LINE_FORCE 8'h4b
`define IDX_SE0_FLAGS 8'h4f
`define IDX_DIFF_DATA 8'h50
`define IDX_PULL_LOW 8'h51
`define IDX_BABBLE 8'h52

`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0

// two-bit line force codes
`define FORCE_NONE 2'h0
`define FORCE_DIFF1 2'h1
`define FORCE_DIFF0 2'h2
`define FORCE_SE0 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** include/hub_port_pkg.sv ***
/*
 types shared by the hub downstream port control block.
 assumes nothing of its surroundings.
*/
package hub_port_pkg;
   typedef logic [1:0] line_force_type;
   typedef logic [1:0] axi_resp_type;
   typedef logic [3:0] port_mask_type;
endpackage : hub_port_pkg

// *** include/port_line_if.sv ***
/*
 carrier between the port control logic and one downstream line module.
 assumes the control side drives settings and the line side reports state.
*/
`timescale 1ns/1ns
interface port_line_if;
   import hub_port_pkg::*;
   line_force_type force_code;
   logic [1:0] pull_low;
   logic low_speed;
   logic clr;
   logic se0;
   logic diff;
   logic idle;
   modport ctrl (output force_code, pull_low, low_speed, clr, input se0, diff, idle);
   modport line (input force_code, pull_low, low_speed, clr, output se0, diff, idle);
endinterface : port_line_if

// *** rtl/port_line.sv ***
/*
 one downstream port: pin synchroniser, se0 and differential readback,
 forced line states and pull-low drive with edge-rate selects.
 assumes pins are asynchronous and settings come from aclk logic.
*/
`timescale 1ns/1ns
`include "hub_port_consts.svh"
module port_line
   import hub_port_pkg::*;
(
   input logic aclk,
   input logic aresetn,
   port_line_if.line ctl,
   input logic dp_pin_i,
   input logic dm_pin_i,
   input logic rep_dp,
   input logic rep_dm,
   input logic rep_oe,
   output logic dp_o,
   output logic dp_oe,
   output logic dm_o,
   output logic dm_oe,
   output logic shape_en,
   output logic slow_edge
);
   logic dp_m_q, dp_s_q, dm_m_q, dm_s_q;
   logic se0_q, diff_q;
   logic dp_q, dpe_q, dm_q, dme_q, shape_q, slow_q;
   wire se0_now = ~dp_s_q & ~dm_s_q;
   wire diff_ok = dp_s_q ^ dm_s_q;
   wire forcing = ctl.force_code != `FORCE_NONE;
   wire force_dp = ctl.force_code == `FORCE_DIFF1;
   wire force_dm = ctl.force_code == `FORCE_DIFF0;
   // a pulled pin wins over both the force field and the repeater
   wire dp_d = ctl.pull_low[1] ? 1'b0 : (forcing ? force_dp : rep_dp);
   wire dm_d = ctl.pull_low[0] ? 1'b0 : (forcing ? force_dm : rep_dm);
   wire dpe_d = ctl.pull_low[1] | forcing | rep_oe;
   wire dme_d = ctl.pull_low[0] | forcing | rep_oe;

   always_ff @(posedge aclk) begin
      dp_m_q <= dp_pin_i;
      dp_s_q <= dp_m_q;
      dm_m_q <= dm_pin_i;
      dm_s_q <= dm_m_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || ctl.clr) begin
         se0_q <= 1'b0;
         diff_q <= 1'b0;
      end else begin
         se0_q <= se0_now;
         // se1 and se0 leave the last differential value standing
         if (diff_ok) begin
            diff_q <= dp_s_q;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dp_q <= 1'b0;
         dpe_q <= 1'b0;
         dm_q <= 1'b0;
         dme_q <= 1'b0;
         shape_q <= 1'b0;
         slow_q <= 1'b0;
      end else begin
         dp_q <= dp_d;
         dpe_q <= dpe_d;
         dm_q <= dm_d;
         dme_q <= dme_d;
         shape_q <= ~|ctl.pull_low;
         slow_q <= ctl.low_speed;
      end
   end

   assign ctl.se0 = se0_q;
   assign ctl.diff = diff_q;
   assign ctl.idle = ctl.low_speed ? (~dp_s_q & dm_s_q) : (dp_s_q & ~dm_s_q);
   assign dp_o = dp_q;
   assign dp_oe = dpe_q;
   assign dm_o = dm_q;
   assign dm_oe = dme_q;
   assign shape_en = shape_q;
   assign slow_edge = slow_q;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pull_low_drive_a: assert property (
      ctl.pull_low[1] |=> (dp_oe && !dp_o && !shape_en))
      else $error("pulled d+ pin not driven low unshaped");
   diff_hold_a: assert property ((se0_now && !ctl.clr) |=> $stable(diff_q))
      else $error("diff readback changed during se0");
endmodule : port_line

// *** rtl/hub_port_ctrl.sv ***
/*
 downstream port control for a four-port full-speed hub repeater:
 enable gating, babble disable at eof2, line forcing, pull-low, readback,
 all reached over an axi4-lite slave.
 assumes the repeater core supplies traffic status on aclk and that
 bus_reset and eof2_strobe are one-cycle or level indications on aclk.
*/
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "hub_port_consts.svh"
module hub_port_ctrl
   import hub_port_pkg::*;
#(
   parameter int AW = 12,
   parameter int NP = 4
)
(
   input logic aclk,
   input logic aresetn,
   input logic bus_reset,
   input logic eof2_strobe,
   input logic hub_suspended,
   input logic hub_int_en,
   input logic [NP-1:0] conn_event,
   input logic us_active,
   input logic us_fs_pkt,
   input logic [NP-1:0] us_link_open,
   input logic [NP-1:0] port_sel_susp,
   input logic rep_ds_dp,
   input logic rep_ds_dm,
   input logic rep_ds_oe,
   input logic [NP-1:0] ds_dp_i,
   input logic [NP-1:0] ds_dm_i,
   output logic [NP-1:0] ds_dp_o,
   output logic [NP-1:0] ds_dp_oe,
   output logic [NP-1:0] ds_dm_o,
   output logic [NP-1:0] ds_dm_oe,
   output logic [NP-1:0] edge_shape_en,
   output logic [NP-1:0] edge_slow,
   output logic [NP-1:0] down_gate,
   output logic [NP-1:0] up_gate,
   output logic conn_irq,
   input logic [AW-1:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input logic [AW-1:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready
);
   // register index from a byte address; low two bits ignored
   function automatic logic [7:0] reg_index(input logic [AW-1:0] a);
      return a[9:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [7:0] idx);
      return idx == `IDX_ENABLES || idx == `IDX_SPEED || idx == `IDX_LINE_FORCE
         || idx == `IDX_SE0_FLAGS || idx == `IDX_DIFF_DATA
         || idx == `IDX_PULL_LOW || idx == `IDX_BABBLE;
   endfunction : is_mapped

   // bus slave state
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [AW-1:0] awaddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   axi_resp_type bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // port control state
   port_mask_type en_q, pend_q, speed_q, babble_q;
   logic [7:0] force_q, pull_q;
   logic conn_irq_q;
   port_mask_type se0_vec, diff_vec, idle_vec;

   wire [7:0] wr_idx = reg_index(awaddr_q);
   wire [7:0] rd_idx = reg_index(araddr);
   wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
   wire wr_ok = wr_fire & wlane_q;
   wire wr_en = wr_ok & (wr_idx == `IDX_ENABLES);
   wire wr_speed = wr_ok & (wr_idx == `IDX_SPEED);
   wire wr_force = wr_ok & (wr_idx == `IDX_LINE_FORCE);
   wire wr_pull = wr_ok & (wr_idx == `IDX_PULL_LOW);
   wire [3:0] wnib = wbyte_q[3:0];

   // a write request in either order; response after both are held
   assign awready = ~aw_have_q & ~bvalid_q;
   assign wready = ~w_have_q & ~bvalid_q;
   assign arready = ~rvalid_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wbyte_q <= wdata[7:0];
            wlane_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read mux; reserved upper bits read zero
   wire [7:0] rd_byte =
      (rd_idx == `IDX_ENABLES) ? {4'h0, en_q} :
      (rd_idx == `IDX_SPEED) ? {4'h0, speed_q} :
      (rd_idx == `IDX_LINE_FORCE) ? force_q :
      (rd_idx == `IDX_SE0_FLAGS) ? {4'h0, se0_vec} :
      (rd_idx == `IDX_DIFF_DATA) ? {4'h0, diff_vec} :
      (rd_idx == `IDX_PULL_LOW) ? pull_q :
      (rd_idx == `IDX_BABBLE) ? {4'h0, babble_q} : `RST_BYTE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
         rdata_q <= {24'h00_0000, rd_byte};
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // babble at the eof2 checkpoint
   wire [3:0] babble_hit = {4{eof2_strobe}} & ((en_q & ~idle_vec) | us_link_open);

   // clears take effect now; new sets wait while a packet is in flight
   wire [3:0] keep_en = wr_en ? (en_q & wnib) : en_q;
   wire [3:0] pend_d = wr_en ? (wnib & ~en_q) : pend_q;
   wire [3:0] land_en = us_active ? 4'h0 : pend_d;
   wire [3:0] en_d = (keep_en | land_en) & ~babble_hit;
   wire [3:0] pend_next = us_active ? (pend_d & ~babble_hit) : 4'h0;
   // a fresh enable write clears the babble mark, but a new hit wins
   wire [3:0] babble_d = (babble_q & ~(wr_en ? wnib : 4'h0)) | babble_hit;

   always_ff @(posedge aclk) begin
      if (!aresetn || bus_reset) begin
         en_q <= `RST_NIBBLE;
         pend_q <= `RST_NIBBLE;
         speed_q <= `RST_NIBBLE;
         babble_q <= `RST_NIBBLE;
      end else begin
         en_q <= en_d;
         pend_q <= pend_next;
         babble_q <= babble_d;
         if (wr_speed) begin
            speed_q <= wnib;
         end
      end
   end

   // force and pull-low survive bus reset; only chip reset clears them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_q <= `RST_BYTE;
         pull_q <= `RST_BYTE;
         conn_irq_q <= 1'b0;
      end else begin
         if (wr_force) begin
            force_q <= wbyte_q;
         end
         if (wr_pull) begin
            pull_q <= wbyte_q;
         end
         conn_irq_q <= hub_suspended & hub_int_en & (|conn_event);
      end
   end
   assign conn_irq = conn_irq_q;

   // traffic gates toward the repeater core
   assign down_gate = en_q & ~port_sel_susp & ~(speed_q & {4{us_fs_pkt}});
   assign up_gate = en_q & ~port_sel_susp & ~babble_q;

   port_line_if lines[NP]();

   genvar i;
   generate
      for (i = 0; i < NP; i++) begin : g_port
         assign lines[i].force_code = force_q[2*i +: 2];
         assign lines[i].pull_low = pull_q[2*i +: 2];
         assign lines[i].low_speed = speed_q[i];
         assign lines[i].clr = bus_reset;
         assign se0_vec[i] = lines[i].se0;
         assign diff_vec[i] = lines[i].diff;
         assign idle_vec[i] = lines[i].idle;
         // a forced port keeps its enable; port_line drives the force code in place of the repeater levels
         port_line u_line (
            .aclk(aclk),
            .aresetn(aresetn),
            .ctl(lines[i]),
            .dp_pin_i(ds_dp_i[i]),
            .dm_pin_i(ds_dm_i[i]),
            .rep_dp(rep_ds_dp),
            .rep_dm(rep_ds_dm),
            .rep_oe(rep_ds_oe & down_gate[i]),
            .dp_o(ds_dp_o[i]),
            .dp_oe(ds_dp_oe[i]),
            .dm_o(ds_dm_o[i]),
            .dm_oe(ds_dm_oe[i]),
            .shape_en(edge_shape_en[i]),
            .slow_edge(edge_slow[i])
         );
      end
   endgenerate

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   idle_babble_a: assert property (
      (eof2_strobe && en_q[0] && !idle_vec[0] && !bus_reset) |=> (!en_q[0] && babble_q[0]))
      else $error("non-idle port at eof2 stayed enabled");
   link_babble_a: assert property (
      (eof2_strobe && us_link_open[1] && !bus_reset) |=> (!en_q[1] && !up_gate[1]))
      else $error("open upstream link at eof2 not disabled");
   // a babble hit at eof2 may legally drop a pending enable
   enable_defer_a: assert property (
      (wr_en && wnib[1] && !en_q[1] && us_active && !eof2_strobe && !bus_reset)
      |=> (!en_q[1] && pend_q[1]))
      else $error("enable took effect during a packet");
   enable_now_a: assert property (
      (wr_en && wnib[2] && !us_active && !eof2_strobe && !bus_reset)
      |=> en_q[2] ##0 (down_gate[2] || port_sel_susp[2] || (speed_q[2] && us_fs_pkt)))
      else $error("idle-bus enable was not immediate");
   // a rewrite that clears the bit cancels the pending enable
   pending_land_a: assert property (
      (pend_q[1] && !us_active && !eof2_strobe && !bus_reset && !(wr_en && !wnib[1]))
      |=> en_q[1])
      else $error("deferred enable not applied after packet");
   bus_reset_a: assert property (
      bus_reset |=> (en_q == 4'h0 && speed_q == 4'h0 && se0_vec == 4'h0 && diff_vec == 4'h0))
      else $error("bus reset left state set");
   ls_withhold_a: assert property (
      (speed_q[1] && us_fs_pkt && rep_ds_oe) |=> (!ds_dp_oe[1] || $past(pull_q[3])
      || $past(force_q[3:2]) != `FORCE_NONE))
      else $error("full-speed traffic reached a low-speed port");
   irq_suspend_a: assert property (
      (hub_suspended && hub_int_en && conn_event[3]) |=> conn_irq)
      else $error("suspended connect event raised no interrupt");
   force_se0_a: assert property (
      (wr_force && wbyte_q[5:4] == `FORCE_SE0)
      |=> ##1 (ds_dp_oe[2] && ds_dm_oe[2] && !ds_dp_o[2] && !ds_dm_o[2]))
      else $error("forced se0 not driven on port 3");
endmodule : hub_port_ctrl

// *** verif/usb_dev_model.sv ***
/*
 behavioural devices on the four downstream ports, pins pulled down.
 assumes the hub's drive wins on any pin whose output enable is high.
*/
`timescale 1ns/1ns
module usb_dev_model (
   input wire logic [3:0] dp_o,
   input wire logic [3:0] dp_oe,
   input wire logic [3:0] dm_o,
   input wire logic [3:0] dm_oe,
   input wire logic [3:0] low_speed,
   input wire logic [7:0] line_state,
   output logic [3:0] dp_i,
   output logic [3:0] dm_i
);
   // line_state per port: 0 detached, 1 idle, 2 resume state, 3 se0
   logic [3:0] dev_dp;
   logic [3:0] dev_dm;
   logic [1:0] st;
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         st = line_state[2*p +: 2];
         // detached or se0 pins fall to the pull-down level, never the last value
         dev_dp[p] = (st == 2'h1) ? ~low_speed[p] : (st == 2'h2) ? low_speed[p] : 1'b0;
         dev_dm[p] = (st == 2'h1 || st == 2'h2) ? ~dev_dp[p] : 1'b0;
         dp_i[p] = dp_oe[p] ? dp_o[p] : dev_dp[p];
         dm_i[p] = dm_oe[p] ? dm_o[p] : dev_dm[p];
      end
   end
endmodule : usb_dev_model

// *** verif/testbench.sv ***
/*
 self-checking bench for the hub downstream port control block.
 assumes an axi4-lite slave that answers in its own time; pins come from the device model.
*/
`timescale 1ns/1ns
`include "hub_port_consts.svh"
module testbench;
   import hub_port_pkg::*;
   logic aclk, aresetn, bus_reset, eof2_strobe, hub_suspended, hub_int_en, us_active, us_fs_pkt;
   logic [3:0] conn_event, us_link_open, ds_dp_i, ds_dm_i, ds_dp_o, ds_dp_oe, ds_dm_o, ds_dm_oe;
   logic [3:0] edge_shape_en, edge_slow, down_gate, up_gate;
   logic conn_irq, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] lines;
   logic rep_ds_dp = 1'b0;
   logic rep_ds_dm = 1'b0;
   logic rep_ds_oe = 1'b0;
   logic [3:0] port_sel_susp = 4'h0;
   int err_count = 0;
   int checks_done = 0;
   logic [7:0] ridx [4] = '{`IDX_ENABLES, `IDX_SPEED, `IDX_LINE_FORCE, `IDX_PULL_LOW};

   hub_port_ctrl #(.AW(12), .NP(4)) i_hub_port_ctrl (.aclk(aclk), .aresetn(aresetn),
      .bus_reset(bus_reset), .eof2_strobe(eof2_strobe), .hub_suspended(hub_suspended),
      .hub_int_en(hub_int_en), .conn_event(conn_event), .us_active(us_active),
      .us_fs_pkt(us_fs_pkt), .us_link_open(us_link_open), .port_sel_susp(port_sel_susp),
      .rep_ds_dp(rep_ds_dp), .rep_ds_dm(rep_ds_dm), .rep_ds_oe(rep_ds_oe),
      .ds_dp_i(ds_dp_i), .ds_dm_i(ds_dm_i), .ds_dp_o(ds_dp_o), .ds_dp_oe(ds_dp_oe),
      .ds_dm_o(ds_dm_o), .ds_dm_oe(ds_dm_oe), .edge_shape_en(edge_shape_en),
      .edge_slow(edge_slow), .down_gate(down_gate), .up_gate(up_gate), .conn_irq(conn_irq),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // port 2 carries a low-speed device
   usb_dev_model i_usb_dev_model (.dp_o(ds_dp_o), .dp_oe(ds_dp_oe), .dm_o(ds_dm_o),
      .dm_oe(ds_dm_oe), .low_speed(4'h2), .line_state(lines), .dp_i(ds_dp_i), .dm_i(ds_dm_i));

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // ready is sampled 1 ns after an edge; it cannot change before the next edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb);
      int n;
      logic aw_h, w_h, b_h;
      n = 0;
      b_h = 1'b0;
      @(posedge aclk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, val};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_h && n < 50) begin
         #1;
         aw_h = awvalid & awready;
         w_h = wvalid & wready;
         b_h = bvalid & bready;
         if (b_h) chk("bresp", 32'(`RESP_OKAY), 32'(bresp));
         @(posedge aclk);
         if (aw_h) awvalid <= 1'b0;
         if (w_h) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!b_h) begin
         err_count++;
         report_and_stop();
      end
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input axi_resp_type er);
      int n;
      logic a_h, r_h;
      n = 0;
      r_h = 1'b0;
      @(posedge aclk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_h && n < 50) begin
         #1;
         a_h = arvalid & arready;
         r_h = rvalid & rready;
         if (r_h) chk($sformatf("reg %h", idx), {24'h0, exp}, rdata);
         if (r_h) chk("rresp", 32'(er), 32'(rresp));
         @(posedge aclk);
         if (a_h) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!r_h) begin
         err_count++;
         report_and_stop();
      end
   endtask : rd

   task automatic eof2();
      @(posedge aclk) eof2_strobe <= 1'b1;
      @(posedge aclk) eof2_strobe <= 1'b0;
   endtask : eof2

   task automatic conn_pulse(input logic [3:0] p, input logic exp);
      @(posedge aclk) conn_event <= p;
      @(posedge aclk) conn_event <= 4'h0;
      #1;
      chk("conn_irq", 32'(exp), 32'(conn_irq));
   endtask : conn_pulse

   initial begin
      aresetn = 1'b0;
      {bus_reset, eof2_strobe, hub_suspended, hub_int_en, us_active, us_fs_pkt} = 6'h00;
      {conn_event, us_link_open} = 8'h00;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      lines = 8'h05;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (ridx[i]) rd(ridx[i], `RST_BYTE, `RESP_OKAY);
      rd(8'h60, 8'h00, `RESP_SLVERR);
      wr(`IDX_SE0_FLAGS, 8'hff, 4'hf);
      wr(`IDX_SPEED, 8'h02, 4'hf);
      wr(`IDX_ENABLES, 8'hff, 4'h0);
      rd(`IDX_ENABLES, 8'h00, `RESP_OKAY);
      wr(`IDX_ENABLES, 8'hff, 4'hf);
      rd(`IDX_ENABLES, 8'h0f, `RESP_OKAY);
      #1;
      chk("up_gate", 32'h0f, 32'(up_gate));
      chk("down_gate", 32'h0f, 32'(down_gate));
      @(posedge aclk) us_fs_pkt <= 1'b1;
      #1;
      chk("down_gate", 32'h0d, 32'(down_gate));
      chk("edge_slow", 32'h02, 32'(edge_slow));
      // one repeater drive cycle: the low-speed port must stay undriven
      @(posedge aclk) rep_ds_oe <= 1'b1;
      @(posedge aclk) rep_ds_oe <= 1'b0;
      #1;
      chk("rep oe", 32'h0d, 32'(ds_dp_oe));
      repeat (4) @(posedge aclk);
      // detached ports sit in se0, which is not idle
      eof2();
      rd(`IDX_ENABLES, 8'h03, `RESP_OKAY);
      @(posedge aclk) lines <= 8'h06;
      repeat (4) @(posedge aclk);
      eof2();
      rd(`IDX_ENABLES, 8'h02, `RESP_OKAY);
      #1;
      chk("up_gate", 32'h02, 32'(up_gate));
      @(posedge aclk) lines <= 8'h05;
      us_link_open <= 4'h2;
      eof2();
      rd(`IDX_ENABLES, 8'h00, `RESP_OKAY);
      @(posedge aclk) us_link_open <= 4'h0;
      us_active <= 1'b1;
      wr(`IDX_ENABLES, 8'h03, 4'hf);
      rd(`IDX_ENABLES, 8'h00, `RESP_OKAY);
      @(posedge aclk) us_active <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(`IDX_ENABLES, 8'h03, `RESP_OKAY);
      wr(`IDX_ENABLES, 8'h00, 4'hf);
      for (int c = 0; c < 4; c++) begin
         wr(`IDX_LINE_FORCE, 8'(c << 4), 4'hf);
         repeat (3) @(posedge aclk);
         #1;
         chk("force oe", (c == 0) ? 32'h0 : 32'h3, 32'({ds_dp_oe[2], ds_dm_oe[2]}));
         if (c != 0) chk("force lvl", 32'({c == 1, c == 2}), 32'({ds_dp_o[2], ds_dm_o[2]}));
         if (c != 0) chk("shape", 32'h1, 32'(edge_shape_en[2]));
      end
      wr(`IDX_LINE_FORCE, 8'h00, 4'hf);
      @(posedge aclk) lines <= 8'h09;
      repeat (6) @(posedge aclk);
      rd(`IDX_DIFF_DATA, 8'h03, `RESP_OKAY);
      rd(`IDX_SE0_FLAGS, 8'h0c, `RESP_OKAY);
      wr(`IDX_PULL_LOW, 8'h03, 4'hf);
      repeat (6) @(posedge aclk);
      #1;
      chk("pull pins", 32'hc, 32'({ds_dp_oe[0], ds_dm_oe[0], ds_dp_o[0], ds_dm_o[0]}));
      chk("pull shape", 32'h0, 32'(edge_shape_en[0]));
      rd(`IDX_SE0_FLAGS, 8'h0d, `RESP_OKAY);
      rd(`IDX_DIFF_DATA, 8'h03, `RESP_OKAY);
      @(posedge aclk) hub_suspended <= 1'b1;
      hub_int_en <= 1'b1;
      conn_pulse(4'h8, 1'b1);
      @(posedge aclk) hub_int_en <= 1'b0;
      conn_pulse(4'h8, 1'b0);
      chk("pull held", 32'hc, 32'({ds_dp_oe[0], ds_dm_oe[0], ds_dp_o[0], ds_dm_o[0]}));
      @(posedge aclk) hub_suspended <= 1'b0;
      wr(`IDX_ENABLES, 8'h02, 4'hf);
      wr(`IDX_LINE_FORCE, 8'h40, 4'hf);
      @(posedge aclk) bus_reset <= 1'b1;
      @(posedge aclk) bus_reset <= 1'b0;
      rd(`IDX_ENABLES, 8'h00, `RESP_OKAY);
      rd(`IDX_SPEED, 8'h00, `RESP_OKAY);
      rd(`IDX_LINE_FORCE, 8'h40, `RESP_OKAY);
      rd(`IDX_PULL_LOW, 8'h03, `RESP_OKAY);
      @(posedge aclk) aresetn <= 1'b0;
      @(posedge aclk) aresetn <= 1'b1;
      rd(`IDX_LINE_FORCE, 8'h00, `RESP_OKAY);
      rd(`IDX_PULL_LOW, 8'h00, `RESP_OKAY);
      wr(`IDX_PULL_LOW, 8'hff, 4'hf);
      repeat (2) @(posedge aclk);
      #1;
      chk("pull all oe", 32'hff, 32'({ds_dp_oe, ds_dm_oe}));
      chk("pull all lvl", 32'h00, 32'({ds_dp_o, ds_dm_o}));
      report_and_stop();
   end
endmodule : testbench
